// *** verilog/mca_pkg.sv ***
// Constants, opcodes and register map of the small ALU core slice
// Operation
// - clear register writes zero, sets zero flag
// - complement register to accumulator or register
// - clear watchdog counter and assigned prescaler
// - clear watchdog sets timeout and powerdown bits
// - compare computes register minus accumulator, flags
// - compare leaves accumulator and register unchanged
// - decimal adjust accumulator, update carry flag
// - decrement register to accumulator or register
// - zero decrement result skips next instruction
`default_nettype none
package mca_pkg;
  // ----------------------------------------------------------------
  // Operations (encoded in the command word, codes 0..5)
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    clear_register_op,
    complement_register_op,
    clear_watchdog_op,
    compare_acc_register_op,
    decimal_adjust_op,
    decrement_skip_zero_op,
    no_op_6,
    no_op_7
  } mca_op_t;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CMD    = 12'h000;
  localparam logic [11:0] ADDR_ACC    = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_WDT    = 12'h00c;
  localparam logic [11:0] ADDR_PSC    = 12'h010;
  localparam logic [11:0] ADDR_FILE   = 12'h100;   // 64 words, one per file register
  localparam logic [3:0]  FILE_PAGE   = 4'h1;      // paddr[11:8] of the file window

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_DEST_BIT = 3;
  localparam int CMD_ADDR_LSB = 8;
  localparam int ST_ZERO      = 0;
  localparam int ST_CARRY     = 1;
  localparam int ST_TIMEOUT   = 2;
  localparam int ST_POWERDOWN = 3;
  localparam int ST_PSC_WDT   = 4;   // Prescaler assigned to watchdog
  localparam int ST_SKIP      = 5;   // Read only: skip cycle in progress

  // ----------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------
  localparam logic [7:0] BYTE_ZERO  = 8'h00;
  localparam logic [7:0] ONE        = 8'h01;
  localparam logic [3:0] BCD_MAX    = 4'h9;
  localparam logic [7:0] ADJ_LOW    = 8'h06;
  localparam logic [7:0] ADJ_HIGH   = 8'h60;
  localparam logic [5:0] STATUS_RST = 6'h0c;   // Timeout and powerdown read 1
endpackage
`default_nettype wire

// *** verilog/mca_alu.sv ***
// Combinational result and flag logic of the six operations
`timescale 1ns/10ps
`default_nettype none
module mca_alu (
  input  wire mca_pkg::mca_op_t op,
  input  wire logic [7:0]       acc,
  input  wire logic [7:0]       rv,
  input  wire logic             cin,
  input  wire logic             dest,
  output logic      [7:0]       res,
  output logic                  z,
  output logic                  c,
  output logic                  wr_acc,
  output logic                  wr_reg,
  output logic                  upd_z,
  output logic                  upd_c,
  output logic                  skip,
  output logic                  wdt_clr
);
  logic [8:0] diff;
  logic [7:0] adj;

  // Result, destination and flag selection per operation
  always_comb begin
    diff    = {1'b0, rv} - {1'b0, acc};
    adj     = acc;
    res     = mca_pkg::BYTE_ZERO;
    c       = cin;
    wr_acc  = 1'b0;
    wr_reg  = 1'b0;
    upd_z   = 1'b0;
    upd_c   = 1'b0;
    skip    = 1'b0;
    wdt_clr = 1'b0;
    case (op)
      mca_pkg::clear_register_op: begin
        res    = mca_pkg::BYTE_ZERO;
        wr_reg = 1'b1;
        upd_z  = 1'b1;
      end
      mca_pkg::complement_register_op: begin
        res    = ~rv;
        wr_acc = ~dest;
        wr_reg = dest;
        upd_z  = 1'b1;
      end
      mca_pkg::clear_watchdog_op: begin
        wdt_clr = 1'b1;
      end
      mca_pkg::compare_acc_register_op: begin
        res   = diff[7:0];
        c     = ~diff[8];
        upd_z = 1'b1;
        upd_c = 1'b1;
      end
      mca_pkg::decimal_adjust_op: begin
        if (acc[3:0] > mca_pkg::BCD_MAX) begin
          adj = acc + mca_pkg::ADJ_LOW;
        end
        if (cin || (adj[7:4] > mca_pkg::BCD_MAX)) begin
          res = adj + mca_pkg::ADJ_HIGH;
          c   = 1'b1;
        end else begin
          res = adj;
          c   = 1'b0;
        end
        wr_acc = 1'b1;
        upd_c  = 1'b1;
      end
      mca_pkg::decrement_skip_zero_op: begin
        res    = rv - mca_pkg::ONE;
        wr_acc = ~dest;
        wr_reg = dest;
        upd_z  = 1'b1;
        // zero result asks for a skip
        skip   = (res == mca_pkg::BYTE_ZERO);
      end
      default: begin
        res = mca_pkg::BYTE_ZERO;
      end
    endcase
    z = (res == mca_pkg::BYTE_ZERO);
  end
endmodule // mca_alu
`default_nettype wire

// *** verilog/mca_core.sv ***
// APB-driven execution core for the clear, compare and adjust operations
`timescale 1ns/10ps
`default_nettype none
module mca_core #(
  parameter int DEPTH    = 64,
  parameter int WDT_W    = 8,
  parameter int PSC_W    = 8
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             timeout_status_bit,
  output logic             powerdown_status_bit,
  output logic             skip_active
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [0:0] { S_RUN, S_SKIP } mca_state_t;

  mca_state_t       state_q, state_d;
  logic [7:0]       mem_q [DEPTH];
  logic [7:0]       mem_d [DEPTH];
  logic [7:0]       acc_q, acc_d;
  logic [5:0]       st_q, st_d;
  logic [WDT_W-1:0] wdt_q, wdt_d;
  logic [PSC_W-1:0] psc_q, psc_d;
  logic [31:0]      prdata_q, prdata_d;
  logic             pready_q, pready_d;
  logic             pslverr_q, pslverr_d;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic            commit;
  logic            exec;
  logic            in_file;
  logic            mapped;
  logic [5:0]      cmd_addr;
  logic [5:0]      file_idx;
  logic [7:0]      rv;
  mca_pkg::mca_op_t op;
  logic [7:0]      res;
  logic            fz, fc, wr_acc, wr_reg, upd_z, upd_c, skip, wdt_clr;

  // Word index of the file window, shared by read and write
  function automatic logic [5:0] file_index(input logic [11:0] a);
    return a[7:2];
  endfunction

  // Write lands only on the edge that completes the transfer
  assign commit   = psel & penable & pready_q & pwrite;
  assign exec     = commit & (paddr == mca_pkg::ADDR_CMD) & pstrb[0];
  assign in_file  = (paddr[11:8] == mca_pkg::FILE_PAGE) && (paddr[1:0] == 2'b00);
  assign mapped   = in_file || (paddr == mca_pkg::ADDR_CMD) || (paddr == mca_pkg::ADDR_ACC)
                 || (paddr == mca_pkg::ADDR_STATUS) || (paddr == mca_pkg::ADDR_WDT)
                 || (paddr == mca_pkg::ADDR_PSC);
  assign op       = mca_pkg::mca_op_t'(pwdata[mca_pkg::CMD_OP_LSB +: 3]);
  assign cmd_addr = pwdata[mca_pkg::CMD_ADDR_LSB +: 6];
  assign file_idx = file_index(paddr);
  assign rv       = mem_q[cmd_addr];

  mca_alu u_alu (
    .op      (op),
    .acc     (acc_q),
    .rv      (rv),
    .cin     (st_q[mca_pkg::ST_CARRY]),
    .dest    (pwdata[mca_pkg::CMD_DEST_BIT]),
    .res     (res),
    .z       (fz),
    .c       (fc),
    .wr_acc  (wr_acc),
    .wr_reg  (wr_reg),
    .upd_z   (upd_z),
    .upd_c   (upd_c),
    .skip    (skip),
    .wdt_clr (wdt_clr)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Bus answer is a flop, so a transfer always sees one wait state;
  // the skip cycle holds the bus off so the discarded slot is visible.
  always_comb begin
    state_d   = S_RUN;
    mem_d     = mem_q;
    acc_d     = acc_q;
    st_d      = st_q;
    psc_d     = psc_q + 1'b1;
    wdt_d     = (st_q[mca_pkg::ST_PSC_WDT] && (psc_q != '1)) ? wdt_q : wdt_q + 1'b1;
    pready_d  = psel & penable & ~pready_q & (state_q == S_RUN);
    pslverr_d = psel & penable & ~pready_q & (state_q == S_RUN) & ~mapped;
    prdata_d  = 32'h0000_0000;
    if (psel && penable && !pready_q && !pwrite) begin
      if (in_file) begin
        prdata_d[7:0] = mem_q[file_idx];
      end else if (paddr == mca_pkg::ADDR_ACC) begin
        prdata_d[7:0] = acc_q;
      end else if (paddr == mca_pkg::ADDR_STATUS) begin
        prdata_d[5:0] = st_q;
        prdata_d[mca_pkg::ST_SKIP] = (state_q == S_SKIP);
      end else if (paddr == mca_pkg::ADDR_WDT) begin
        prdata_d[WDT_W-1:0] = wdt_q;
      end else if (paddr == mca_pkg::ADDR_PSC) begin
        prdata_d[PSC_W-1:0] = psc_q;
      end
    end
    // Plain register writes
    if (commit && pstrb[0]) begin
      if (in_file) begin
        mem_d[file_idx] = pwdata[7:0];
      end else if (paddr == mca_pkg::ADDR_ACC) begin
        acc_d = pwdata[7:0];
      end else if (paddr == mca_pkg::ADDR_STATUS) begin
        st_d = {1'b0, pwdata[4:0]};
      end
    end
    // Instruction execution
    if (exec) begin
      if (wr_acc) begin
        acc_d = res;
      end
      if (wr_reg) begin
        mem_d[cmd_addr] = res;
      end
      if (upd_z) begin
        st_d[mca_pkg::ST_ZERO] = fz;
      end
      if (upd_c) begin
        st_d[mca_pkg::ST_CARRY] = fc;
      end
      if (wdt_clr) begin
        wdt_d = '0;
        if (st_q[mca_pkg::ST_PSC_WDT]) begin
          psc_d = '0;
        end
        st_d[mca_pkg::ST_TIMEOUT]   = 1'b1;
        st_d[mca_pkg::ST_POWERDOWN] = 1'b1;
      end
      if (skip) begin
        state_d = S_SKIP;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Clock enable freezes every flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q   <= S_RUN;
      mem_q     <= '{default: 8'h00};
      acc_q     <= mca_pkg::BYTE_ZERO;
      st_q      <= mca_pkg::STATUS_RST;
      wdt_q     <= '0;
      psc_q     <= '0;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      state_q   <= state_d;
      mem_q     <= mem_d;
      acc_q     <= acc_d;
      st_q      <= st_d;
      wdt_q     <= wdt_d;
      psc_q     <= psc_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata               = prdata_q;
  assign pready               = pready_q;
  assign pslverr              = pslverr_q;
  assign timeout_status_bit   = st_q[mca_pkg::ST_TIMEOUT];
  assign powerdown_status_bit = st_q[mca_pkg::ST_POWERDOWN];
  assign skip_active          = (state_q == S_SKIP);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic go;
  assign go = exec & ce;

  chk_clear_reg_zero: assert property (@(posedge pclk) disable iff (!presetn)
    go && op == mca_pkg::clear_register_op |=> mem_q[$past(cmd_addr)] == 8'h00
      && st_q[mca_pkg::ST_ZERO]) else $error("clear register left data or zero flag");
  chk_comp_to_acc: assert property (@(posedge pclk) disable iff (!presetn)
    go && op == mca_pkg::complement_register_op && !pwdata[3] |=> acc_q == ~$past(rv))
    else $error("complement not in accumulator");
  chk_wdt_cleared: assert property (@(posedge pclk) disable iff (!presetn)
    go && op == mca_pkg::clear_watchdog_op |=> wdt_q == '0)
    else $error("watchdog not cleared");
  chk_wdt_status_set: assert property (@(posedge pclk) disable iff (!presetn)
    go && op == mca_pkg::clear_watchdog_op |=> timeout_status_bit && powerdown_status_bit)
    else $error("timeout or powerdown not set");
  chk_cmp_carry: assert property (@(posedge pclk) disable iff (!presetn)
    go && op == mca_pkg::compare_acc_register_op
      |=> st_q[mca_pkg::ST_CARRY] == ($past(rv) >= $past(acc_q))
      && st_q[mca_pkg::ST_ZERO] == ($past(rv) == $past(acc_q)))
    else $error("compare flags wrong");
  chk_cmp_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    go && op == mca_pkg::compare_acc_register_op |=> $stable(acc_q)
      && mem_q[$past(cmd_addr)] == $past(rv)) else $error("compare changed data");
  chk_daa_carry: assert property (@(posedge pclk) disable iff (!presetn)
    go && op == mca_pkg::decimal_adjust_op && st_q[mca_pkg::ST_CARRY]
      |=> st_q[mca_pkg::ST_CARRY]) else $error("decimal adjust lost carry");
  chk_dec_reg: assert property (@(posedge pclk) disable iff (!presetn)
    go && op == mca_pkg::decrement_skip_zero_op && pwdata[3]
      |=> mem_q[$past(cmd_addr)] == $past(rv) - 8'h01) else $error("decrement wrong");
  chk_skip_slot: assert property (@(posedge pclk) disable iff (!presetn)
    go && op == mca_pkg::decrement_skip_zero_op && rv == 8'h01
      |=> skip_active ##1 !pready) else $error("skip cycle missing");
  chk_zero_flag: assert property (@(posedge pclk) disable iff (!presetn)
    go && op == mca_pkg::complement_register_op |=> st_q[mca_pkg::ST_ZERO] == ($past(rv) == 8'hff))
    else $error("complement zero flag wrong");

  cov_skip: cover property (@(posedge pclk) disable iff (!presetn) go && skip);
  cov_wdt: cover property (@(posedge pclk) disable iff (!presetn) go && wdt_clr);
  cov_cmp_eq: cover property (@(posedge pclk) disable iff (!presetn)
    go && op == mca_pkg::compare_acc_register_op && rv == acc_q);
endmodule // mca_core
`default_nettype wire

// *** tb/mca_testbench.sv ***
// Self-checking bench of the clear, compare and adjust execution core
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // ----------------------------------------------------------------
  // Signals and operation table
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] op;   // Operation code
    logic       d;    // Destination select
    logic [7:0] r;    // File register before
    logic [7:0] a;    // Accumulator before
    logic       ci;   // Carry before
    logic [7:0] ef;   // File register after
    logic [7:0] ea;   // Accumulator after
    logic       ez;   // Zero flag after
    logic       ec;   // Carry flag after
  } mca_tb_row_t;

  localparam logic [11:0] FREG = mca_pkg::ADDR_FILE + 12'h024;   // File register 9

  mca_tb_row_t rows [16] = '{
    '{3'h0, 1'b0, 8'h55, 8'h33, 1'b0, 8'h00, 8'h33, 1'b1, 1'b0},
    '{3'h1, 1'b1, 8'ha6, 8'h33, 1'b1, 8'h59, 8'h33, 1'b0, 1'b1},
    '{3'h1, 1'b0, 8'ha6, 8'h33, 1'b0, 8'ha6, 8'h59, 1'b0, 1'b0},
    '{3'h1, 1'b1, 8'hff, 8'h33, 1'b0, 8'h00, 8'h33, 1'b1, 1'b0},
    '{3'h3, 1'b0, 8'h34, 8'h12, 1'b0, 8'h34, 8'h12, 1'b0, 1'b1},
    '{3'h3, 1'b0, 8'h12, 8'h34, 1'b1, 8'h12, 8'h34, 1'b0, 1'b0},
    '{3'h3, 1'b0, 8'h5a, 8'h5a, 1'b0, 8'h5a, 8'h5a, 1'b1, 1'b1},
    '{3'h4, 1'b0, 8'h00, 8'h4d, 1'b0, 8'h00, 8'h53, 1'b0, 1'b0},
    '{3'h4, 1'b0, 8'h00, 8'ha0, 1'b0, 8'h00, 8'h00, 1'b0, 1'b1},
    '{3'h4, 1'b0, 8'h00, 8'h12, 1'b1, 8'h00, 8'h72, 1'b0, 1'b1},
    '{3'h4, 1'b0, 8'h00, 8'h42, 1'b0, 8'h00, 8'h42, 1'b0, 1'b0},
    '{3'h5, 1'b1, 8'h02, 8'h33, 1'b0, 8'h01, 8'h33, 1'b0, 1'b0},
    '{3'h5, 1'b1, 8'h01, 8'h33, 1'b1, 8'h00, 8'h33, 1'b1, 1'b1},
    '{3'h5, 1'b0, 8'h01, 8'h33, 1'b0, 8'h01, 8'h00, 1'b1, 1'b0},
    '{3'h5, 1'b0, 8'h00, 8'h33, 1'b0, 8'h00, 8'hff, 1'b0, 1'b0},
    '{3'h6, 1'b1, 8'h44, 8'h33, 1'b1, 8'h44, 8'h33, 1'b0, 1'b1}
  };

  logic        pclk                 = 1'b0;
  logic        presetn              = 1'b0;
  logic        psel                 = 1'b0;
  logic        penable              = 1'b0;
  logic        pwrite               = 1'b0;
  logic [11:0] paddr                = 12'h000;
  logic [31:0] pwdata               = 32'h0000_0000;
  logic [3:0]  pstrb                = 4'hf;
  logic        ce                   = 1'b1;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        timeout_status_bit;
  logic        powerdown_status_bit;
  logic        skip_active;
  logic [31:0] rdat;
  logic        rerr;
  logic [31:0] wval;
  logic        sk;
  int          lat;
  int          cyc                  = 0;
  int          err_count            = 0;
  int          n_checks             = 0;

  // Clock enable is dropped once to show that state freezes
  mca_core dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timeout_status_bit(timeout_status_bit),
    .powerdown_status_bit(powerdown_status_bit), .skip_active(skip_active)
  );

  // 125 MHz clock
  always #4 pclk = ~pclk;

  // ----------------------------------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask

  // Request stays up after the answer so a next setup may follow at once
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] v,
                      input logic [3:0] s);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= v;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    lat = 0;
    do begin
      @(posedge pclk);
      lat++;
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    xfer(1'b1, a, v, 4'hf);
  endtask

  task automatic rd(input logic [11:0] a);
    xfer(1'b0, a, 32'h0, 4'hf);
  endtask

  task automatic exe(input logic [2:0] op, input logic d, input logic [5:0] i);
    wr(mca_pkg::ADDR_CMD, {18'h0, i, 4'h0, d, op});
  endtask

  task automatic idle(input int n);
    psel    <= 1'b0;
    penable <= 1'b0;
    repeat (n) @(posedge pclk);
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Hang guard, far above the roughly 1350 cycles the run needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("timeout pin", 32'h1, 32'(timeout_status_bit));
    chk("powerdown pin", 32'h1, 32'(powerdown_status_bit));
    rd(mca_pkg::ADDR_STATUS);
    chk("status reset", 32'h0000_000c, rdat);
    chk("status error", 32'h0, 32'(rerr));
    // Long run first so both counters hold nonzero values
    wr(mca_pkg::ADDR_STATUS, 32'h0000_0010);
    idle(600);
    exe(3'h2, 1'b0, 6'h00);
    idle(1);
    chk("timeout pin", 32'h1, 32'(timeout_status_bit));
    chk("powerdown pin", 32'h1, 32'(powerdown_status_bit));
    rd(mca_pkg::ADDR_WDT);
    chk("watchdog", 32'h0, rdat);
    rd(mca_pkg::ADDR_PSC);
    chk("prescaler low", 32'h1, 32'(rdat < 32'd16));
    // Unassigned prescaler: watchdog restarts and counts every cycle
    wr(mca_pkg::ADDR_STATUS, 32'h0000_000c);
    idle(300);
    exe(3'h2, 1'b0, 6'h00);
    rd(mca_pkg::ADDR_WDT);
    chk("watchdog low", 32'h1, 32'(rdat < 32'd16));
    // Clock enable low for 40 edges: watchdog must not move meanwhile
    rd(mca_pkg::ADDR_WDT);
    wval = rdat;
    ce   <= 1'b0;
    idle(40);
    ce   <= 1'b1;
    rd(mca_pkg::ADDR_WDT);
    chk("frozen watchdog", 32'h1, 32'((rdat[7:0] - wval[7:0]) < 8'd16));
    foreach (rows[k]) begin
      wr(FREG, 32'(rows[k].r));
      wr(mca_pkg::ADDR_ACC, 32'(rows[k].a));
      wr(mca_pkg::ADDR_STATUS, {30'h3, rows[k].ci, 1'b0});
      exe(rows[k].op, rows[k].d, 6'h09);
      // Release the bus and look at the skip slot on the next edge
      idle(1);
      sk = (rows[k].op == 3'h5) && rows[k].ez;
      chk("skip pin", 32'(sk), 32'(skip_active));
      rd(mca_pkg::ADDR_ACC);
      chk("answer delay", 32'd2, 32'(lat));
      chk("accumulator", 32'(rows[k].ea), rdat);
      rd(FREG);
      chk("file register", 32'(rows[k].ef), rdat);
      rd(mca_pkg::ADDR_STATUS);
      chk("status", {30'h3, rows[k].ec, rows[k].ez}, rdat);
    end
    // Refused accesses leave state alone
    wr(mca_pkg::ADDR_ACC, 32'h0000_0011);
    xfer(1'b1, mca_pkg::ADDR_ACC, 32'h0000_0022, 4'h0);
    rd(mca_pkg::ADDR_ACC);
    chk("masked write", 32'h0000_0011, rdat);
    rd(12'h020);
    chk("unmapped error", 32'h1, 32'(rerr));
    chk("unmapped data", 32'h0, rdat);
    idle(2);
    stop_test();
  end
endmodule // testbench
`default_nettype wire
